// ==== hdl/writ_target.sv ====
// two-wire target holding the 7-bit wiper position register
// Contract
// - target acks ident, address, data on write, then ignores the bus until the next start or stop
// - data bits shift in one by one; wiper untouched until byte done
// - address zero: data copied to wiper on falling clock of last bit
// - no ack for nonzero address or foreign target code
// - update only with valid ident, address and exact clock count
// - target acks both ident bytes and the address on a read
// - target keeps sending bytes while controller acks after eighth bit
// - ident byte is 7-bit code then direction bit, 1 read, 0 write
// - wiper register presets to 40h at power-up
// - every byte travels most significant bit first
`timescale 1ns/10ps
module writ_target
	import writ_pkg::*;
(
	input  wire logic       core_clk_in,
	input  wire logic       rst_b_in,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_out,
	output logic [6:0]      wiper_out
);
	typedef struct packed
	{
		writ_state_e state;
		logic [7:0]  shift;
		logic [3:0]  bitcnt;
		logic        in_ack;
		logic        ack_ok;
		logic        addr_ok;
		logic        dir_rd;
		logic [6:0]  wiper;
		logic        sda_o;
		logic        sda_oe;
	} writ_state_s;

	writ_state_s st_q;
	writ_state_s st_d;

	logic scl_s;
	logic scl_p;
	logic sda_s;
	logic sda_p;

	writ_sync u_scl
	(
		.core_clk_in (core_clk_in),
		.rst_b_in    (rst_b_in),
		.async_in    (scl_in),
		.sync_out    (scl_s),
		.prev_out    (scl_p)
	);

	writ_sync u_sda
	(
		.core_clk_in (core_clk_in),
		.rst_b_in    (rst_b_in),
		.async_in    (sda_in),
		.sync_out    (sda_s),
		.prev_out    (sda_p)
	);

	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic [7:0] rx_byte;

	assign scl_rise = scl_s & ~scl_p;
	assign scl_fall = ~scl_s & scl_p;
	assign start_c  = scl_s & scl_p & sda_p & ~sda_s;
	assign stop_c   = scl_s & scl_p & ~sda_p & sda_s;
	assign rx_byte  = st_q.shift;

	always_comb
	begin
		st_d = st_q;
		if (start_c)
		begin
			// a restart keeps the address validity for the read that follows
			st_d.state  = WRIT_IDENT;
			st_d.bitcnt = 4'h0;
			st_d.in_ack = 1'b0;
			st_d.sda_oe = 1'b0;
		end
		else if (stop_c)
		begin
			st_d.state   = WRIT_IDLE;
			st_d.addr_ok = 1'b0;
			st_d.in_ack  = 1'b0;
			st_d.sda_oe  = 1'b0;
		end
		else
		begin
			case (st_q.state)
				WRIT_IDLE, WRIT_IGNORE:
				begin
					st_d.sda_oe = 1'b0;
				end
				WRIT_IDENT, WRIT_ADDR, WRIT_DATA:
				begin
					if (scl_rise && !st_q.in_ack)
					begin
						st_d.shift  = {st_q.shift[6:0], sda_s};
						st_d.bitcnt = st_q.bitcnt + 4'h1;
					end
					else if (scl_fall && !st_q.in_ack && st_q.bitcnt == WRIT_BITS_PER_BYTE)
					begin
						st_d.in_ack = 1'b1;
						st_d.ack_ok = 1'b0;
						if (st_q.state == WRIT_IDENT)
						begin
							st_d.ack_ok = (rx_byte[7:1] == WRIT_TARGET_CODE);
							st_d.dir_rd = (rx_byte[0] == WRIT_DIR_READ);
							if (rx_byte[0] == WRIT_DIR_READ && !st_q.addr_ok)
								st_d.ack_ok = 1'b0;
						end
						else if (st_q.state == WRIT_ADDR)
						begin
							st_d.ack_ok  = (rx_byte == WRIT_REG_WIPER);
							st_d.addr_ok = (rx_byte == WRIT_REG_WIPER);
						end
						else
						begin
							st_d.ack_ok = 1'b1;
							if (st_q.addr_ok)
								st_d.wiper = rx_byte[6:0];
						end
						st_d.sda_o  = 1'b0;
						st_d.sda_oe = st_d.ack_ok;
					end
					else if (scl_fall && st_q.in_ack)
					begin
						st_d.in_ack = 1'b0;
						st_d.sda_oe = 1'b0;
						st_d.bitcnt = 4'h0;
						if (!st_q.ack_ok)
							st_d.state = WRIT_IGNORE;
						else if (st_q.state == WRIT_IDENT && st_q.dir_rd)
						begin
							st_d.state  = WRIT_SEND;
							st_d.shift  = {1'b0, st_q.wiper};
							st_d.sda_o  = 1'b0;
							st_d.sda_oe = 1'b0;
						end
						else if (st_q.state == WRIT_IDENT)
							st_d.state = WRIT_ADDR;
						else if (st_q.state == WRIT_ADDR)
							st_d.state = WRIT_DATA;
						else
							st_d.state = WRIT_IGNORE;
					end
				end
				WRIT_SEND:
				begin
					if (scl_fall && st_q.bitcnt != WRIT_BITS_PER_BYTE)
					begin
						// drive msb first, then shift up
						st_d.sda_o  = st_q.shift[7];
						st_d.sda_oe = ~st_q.shift[7];
						st_d.shift  = {st_q.shift[6:0], 1'b0};
						st_d.bitcnt = st_q.bitcnt + 4'h1;
					end
					else if (scl_fall)
					begin
						st_d.sda_oe = 1'b0;
						st_d.state  = WRIT_ACKCHK;
					end
				end
				WRIT_ACKCHK:
				begin
					// ack taken on the rise, next byte waits for the fall: sda stays put while scl high
					if (scl_rise)
					begin
						if (!sda_s)
							st_d.in_ack = 1'b1;
						else
							st_d.state = WRIT_IGNORE;
					end
					else if (scl_fall && st_q.in_ack)
					begin
						st_d.in_ack = 1'b0;
						st_d.shift  = {1'b0, st_q.wiper};
						st_d.bitcnt = 4'h0;
						st_d.state  = WRIT_SEND;
					end
				end
				default:
				begin
					st_d.state = WRIT_IDLE;
				end
			endcase
		end
		// send starts on the ack-release fall, so first bit is driven now
		if (st_q.state != WRIT_SEND && st_d.state == WRIT_SEND)
		begin
			st_d.sda_o  = st_d.shift[7];
			st_d.sda_oe = ~st_d.shift[7];
			st_d.shift  = {st_d.shift[6:0], 1'b0};
			st_d.bitcnt = 4'h1;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			st_q.state   <= WRIT_IDLE;
			st_q.shift   <= 8'h00;
			st_q.bitcnt  <= 4'h0;
			st_q.in_ack  <= 1'b0;
			st_q.ack_ok  <= 1'b0;
			st_q.addr_ok <= 1'b0;
			st_q.dir_rd  <= 1'b0;
			st_q.wiper   <= WRIT_WIPER_RESET;
			st_q.sda_o   <= 1'b0;
			st_q.sda_oe  <= 1'b0;
		end
		else
			st_q <= st_d;
	end

	assign sda_out    = st_q.sda_o;
	assign sda_oe_out = st_q.sda_oe;
	assign wiper_out  = st_q.wiper;
endmodule

// ==== hdl/writ_pkg.sv ====
// package: constants for the wiper register two-wire target
package writ_pkg;
	localparam logic [6:0] WRIT_TARGET_CODE  = 7'h2a; // arbitrary target code
	localparam logic [7:0] WRIT_REG_WIPER    = 8'h00;
	localparam logic [6:0] WRIT_WIPER_RESET  = 7'h40;
	localparam logic       WRIT_DIR_READ     = 1'b1;
	localparam logic       WRIT_DIR_WRITE    = 1'b0;
	localparam logic [3:0] WRIT_BITS_PER_BYTE = 4'h8;

	typedef enum logic [2:0]
	{
		WRIT_IDLE   = 3'b000,
		WRIT_IDENT  = 3'b001,
		WRIT_ADDR   = 3'b011,
		WRIT_DATA   = 3'b010,
		WRIT_SEND   = 3'b110,
		WRIT_ACKCHK = 3'b111,
		WRIT_IGNORE = 3'b101
	} writ_state_e;
endpackage

// ==== hdl/writ_sync.sv ====
// two-flop synchroniser with one-cycle delayed copy for edge detection
`timescale 1ns/10ps
module writ_sync
	import writ_pkg::*;
(
	input  wire logic core_clk_in,
	input  wire logic rst_b_in,
	input  wire logic async_in,
	output logic      sync_out,
	output logic      prev_out
);
	typedef struct packed
	{
		logic meta;
		logic sync;
		logic prev;
	} writ_sync_s;

	writ_sync_s st_q;
	writ_sync_s st_d;

	always_comb
	begin
		st_d.meta = async_in;
		st_d.sync = st_q.meta;
		st_d.prev = st_q.sync;
	end

	// bus idles high, so reset to high avoids a false edge
	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			st_q <= 3'h7;
		else
			st_q <= st_d;
	end

	assign sync_out = st_q.sync;
	assign prev_out = st_q.prev;
endmodule

// ==== test/writ_target_props.sv ====
// port assertions for the wiper register target
`timescale 1ns/10ps
module writ_target_props
	import writ_pkg::*;
(
	input wire logic       core_clk_in,
	input wire logic       rst_b_in,
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe_out,
	input wire logic [6:0] wiper_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	a_open_drain: assert property (sda_oe_out |-> !sda_out)
		else $error("sda driven high");
	a_reset_val: assert property ($rose(rst_b_in) |-> wiper_out == WRIT_WIPER_RESET)
		else $error("wiper preset");
	a_commit_ack: assert property ($changed(wiper_out) |-> $rose(sda_oe_out))
		else $error("commit without ack");
	a_commit_low: assert property ($changed(wiper_out) |-> !scl_in && !$past(scl_in, 2))
		else $error("commit off clock fall");
	a_commit_once: assert property ($changed(wiper_out) |=> $stable(wiper_out) [*8])
		else $error("wiper changed twice");
	a_ack_hold: assert property ($rose(sda_oe_out) |-> sda_oe_out [*4])
		else $error("ack too short");
	a_drive_low: assert property ($changed(sda_oe_out) |-> !scl_in)
		else $error("sda moved with scl high");
	a_stop_idle: assert property ($rose(sda_in) && scl_in |=> !sda_oe_out [*3])
		else $error("driving after stop");
endmodule
bind writ_target writ_target_props u_props (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
	.wiper_out(wiper_out));

// ==== test/writ_host.sv ====
// host controller model that clocks the two-wire bus
`timescale 1ns/10ps
module writ_host
(
	input  wire logic clk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_out
);
	initial
	begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task automatic w(int n);
		repeat (n) @(negedge clk_in);
	endtask
	// also a repeated start: entered with scl low
	task automatic start;
		sda_out = 1'b1;
		w(6);
		scl_out = 1'b1;
		w(6);
		sda_out = 1'b0;
		w(6);
		scl_out = 1'b0;
	endtask
	task automatic stop;
		w(2);
		sda_out = 1'b0;
		w(6);
		scl_out = 1'b1;
		w(6);
		sda_out = 1'b1;
		w(6);
	endtask
	// t[0] is what the host puts on the ninth clock, 1 releases
	task automatic xfer(input logic [8:0] t, output logic [8:0] r);
		for (int i = 8; i >= 0; i--)
		begin
			w(2);
			sda_out = t[i];
			w(6);
			scl_out = 1'b1;
			w(6);
			r[i] = sda_in;
			scl_out = 1'b0;
		end
	endtask
endmodule

// ==== test/tb.sv ====
// bench for the wiper register target
`timescale 1ns/10ps
module tb
	import writ_pkg::*;
;
	logic       clk, rst_b, scl, sda_rel, sda_oe, sda_d;
	logic [6:0] wiper;
	logic [8:0] rx;
	int         failures, comparisons;
	wire        sda = sda_rel & !sda_oe;
	localparam logic [8:0] IDW = {WRIT_TARGET_CODE, WRIT_DIR_WRITE, 1'b1};
	localparam logic [8:0] IDR = {WRIT_TARGET_CODE, WRIT_DIR_READ, 1'b1};
	writ_target DUT (.core_clk_in(clk), .rst_b_in(rst_b), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_d), .sda_oe_out(sda_oe), .wiper_out(wiper));
	writ_host host (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_out(sda_rel));
	task chk(string n, logic [7:0] e, logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task final_report;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// one byte plus ninth clock, checking the ack level seen
	task s(logic [8:0] t, logic e);
		host.xfer(t, rx);
		chk("ack", {7'h00, e}, {7'h00, rx[0]});
	endtask
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial
	begin
		repeat (60000) @(posedge clk);
		failures++;
		final_report();
	end
	initial
	begin
		rst_b = 1'b0;
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		chk("preset", {1'b0, WRIT_WIPER_RESET}, {1'b0, wiper});
		host.start();
		s(IDW, 1'b0);
		s({WRIT_REG_WIPER, 1'b1}, 1'b0);
		s(9'h1ab, 1'b0);
		host.stop();
		chk("write", 8'h55, {1'b0, wiper});
		$display("write test done");
		host.start();
		s(IDW, 1'b0);
		s({WRIT_REG_WIPER, 1'b1}, 1'b0);
		host.start();
		s(IDR, 1'b0);
		host.xfer(9'h1fe, rx);
		chk("read 1", 8'h55, rx[8:1]);
		host.xfer(9'h1ff, rx);
		chk("read 2", 8'h55, rx[8:1]);
		host.stop();
		$display("read test done");
		host.start();
		s({WRIT_TARGET_CODE ^ 7'h01, WRIT_DIR_WRITE, 1'b1}, 1'b1);
		host.stop();
		host.start();
		s(IDW, 1'b0);
		s(9'h003, 1'b1);
		s(9'h0ff, 1'b1);
		host.stop();
		chk("guard", 8'h55, {1'b0, wiper});
		host.start();
		s(IDR, 1'b1);
		host.stop();
		$display("refusal test done");
		final_report();
	end
endmodule
